// >>> inc/iom_defs.svh
// register offsets, field positions, reset values and overhead slot numbers
`ifndef IOM_DEFS_SVH
`define IOM_DEFS_SVH
`define IOM_OFS_CTRL 4'h0
`define IOM_OFS_STAT 4'h4
`define IOM_OFS_FILL 4'h8
`define IOM_CTRL_RST 32'h0000_0000
`define IOM_CTRL_ENH 0
`define IOM_CTRL_TWO_WIRE 1
`define IOM_CTRL_CLOSED_NET 2
`define IOM_CTRL_BWD_TX 3
`define IOM_CTRL_DNI_LO 4
`define IOM_CTRL_DNI_HI 6
`define IOM_STAT_OVF_LO 0
`define IOM_STAT_FAW_ERR 4
`define IOM_STAT_BWD_RX 5
`define IOM_STAT_ENH_ACT 6
`define IOM_BYTE_FLAG1 6'h01
`define IOM_BYTE_SIG16 6'h10
`define IOM_BYTE_HK32 6'h20
`define IOM_BYTE_SIG48 6'h30
`define IOM_BIT1 7
`define IOM_BIT2 6
`define IOM_BIT3 5
`define IOM_BIT4 4
`define IOM_BIT6 2
`define IOM_FIFO_DEPTH 32
`endif

// >>> inc/iom_pkg.sv
// types shared by the overhead multiplexer
package iom_pkg;
	typedef struct packed {
		logic vld;
		logic [7:0] data;
	} iom_byte_t;
	typedef enum logic [2:0] {
		IOM_DNI_NONE = 3'h0,
		IOM_DNI_T31 = 3'h1,
		IOM_DNI_T30CAS = 3'h2,
		IOM_DNI_OTHER = 3'h3
	} iom_dni_t;
endpackage

// >>> rtl/iom_overhead_mux.sv
// overhead housekeeping and station link channel multiplexer
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "iom_defs.svh"
// Behaviour
// - normal mode carries station link bit raw in bit 1 of byte 32.
// - normal channel rate is one bit per 512 aggregate bits.
// - byte 32 bit 2 is a frame alignment bit, sent and checked.
// - byte 32 bit 3 carries backward alarm both ways; received value reported.
// - byte 32 bit 4 carries the multiframe message unchanged.
// - normal mode sends zero in bits 5 to 8, ignores them on receive.
// - overhead takes one sixteenth; through data keeps fifteen sixteenths.
// - normal channel is raw and unbuffered, no clock output.
// - enhanced mode, chosen by software, carries data in bytes 16 and 48.
// - enhanced rate is sixteen normal bits, one per 32 aggregate bits.
// - byte 1 bit 1 and byte 32 bit 6 flag enhanced data present.
// - enhanced mode works only with closed network mode selected.
// - enhanced mode reassigns overhead bits and buffers the channel.
// - primary and secondary channels each have 32 byte transmit and receive FIFOs.
// - FIFO loses nothing at differing rates; overflow purges whole content.
// - idle gaps take no FIFO space; slow user leaves gaps.
// - among drop and insert modes only 31 slot and 30 slot cas allow enhanced.
// - other drop and insert modes keep bytes 16 and 48 for signaling.
// - two-wire mode mutes user input while output to user is active.
// - software picks normal or enhanced; mode sets channel interface behaviour.
module iom_overhead_mux import iom_pkg::*; #(
	parameter int DEPTH = `IOM_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic tx_ovh_req,
	input wire logic [5:0] tx_ovh_idx,
	input wire logic faw_tx_bit,
	input wire logic mf_tx_bit,
	output logic tx_ovh_vld,
	output logic [7:0] tx_ovh_byte,
	input wire logic rx_ovh_vld,
	input wire logic [5:0] rx_ovh_idx,
	input wire logic [7:0] rx_ovh_byte,
	input wire logic faw_exp_bit,
	output logic faw_err,
	output logic mf_rx_bit,
	output logic bwd_alarm_rx,
	input wire logic slc_in_pin,
	output logic slc_out_pin,
	input wire iom_byte_t [1:0] usr_in,
	output logic [1:0] usr_in_rdy,
	output iom_byte_t [1:0] usr_out,
	input wire logic [1:0] usr_out_rdy
);
	localparam int AW = $clog2(DEPTH);

	// pointers wrap by carry, so only a power of two depth keeps count and index aligned
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin
		$error("DEPTH must be a power of two of at least 2");
	end

	logic rst_meta_r;
	logic rst_s;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_r <= 1'b0;
			rst_s <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_s <= rst_meta_r;
		end
	end

	// control register
	logic [31:0] ctrl_r;
	logic enh_act_r;
	iom_dni_t dni;
	logic two_wire;
	assign dni = iom_dni_t'(ctrl_r[`IOM_CTRL_DNI_HI:`IOM_CTRL_DNI_LO]);
	assign two_wire = ctrl_r[`IOM_CTRL_TWO_WIRE];

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			ctrl_r <= `IOM_CTRL_RST;
		end else if (reg_wr && reg_addr == `IOM_OFS_CTRL) begin
			ctrl_r <= {25'h0, reg_wdata[6:0]};
		end
	end

	// enhanced only when chosen, closed net, and a drop and insert mode that frees 16/48
	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			enh_act_r <= 1'b0;
		end else begin
			enh_act_r <= ctrl_r[`IOM_CTRL_ENH] && ctrl_r[`IOM_CTRL_CLOSED_NET] &&
				(dni == IOM_DNI_NONE || dni == IOM_DNI_T31 || dni == IOM_DNI_T30CAS);
		end
	end

	// fifo 0/1 carry primary/secondary toward the link, 2/3 from the link
	logic [7:0] mem_r [4][DEPTH];
	logic [AW-1:0] wp_r [4];
	logic [AW-1:0] rp_r [4];
	logic [AW:0] cnt_r [4];
	logic [3:0] push;
	logic [3:0] pop;
	logic [3:0] purge;
	logic [7:0] din [4];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			purge[i] = push[i] && !pop[i] && cnt_r[i] == (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			for (int i = 0; i < 4; i++) begin
				wp_r[i] <= '0;
				rp_r[i] <= '0;
				cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (purge[i]) begin
					// the overflowing byte goes with the rest; a partial message is worse
					wp_r[i] <= '0;
					rp_r[i] <= '0;
					cnt_r[i] <= '0;
				end else begin
					if (push[i]) begin
						wp_r[i] <= wp_r[i] + 1'b1;
					end
					if (pop[i]) begin
						rp_r[i] <= rp_r[i] + 1'b1;
					end
					cnt_r[i] <= cnt_r[i] + (AW+1)'(push[i]) - (AW+1)'(pop[i]);
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < 4; i++) begin
			if (push[i] && !purge[i]) begin
				mem_r[i][wp_r[i]] <= din[i];
			end
		end
	end

	// user side: bytes only enter on a valid, so idle gaps cost nothing
	logic mute;
	assign mute = two_wire && (usr_out[0].vld || usr_out[1].vld);
	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			usr_in_rdy <= 2'h0;
		end else begin
			usr_in_rdy <= {2{enh_act_r && !mute}};
		end
	end

	logic tx_pop_pri;
	logic tx_pop_sec;
	logic [1:0] rx_push;
	logic [1:0] rx_pop;

	always_comb begin
		push[0] = usr_in[0].vld && usr_in_rdy[0] && !mute;
		push[1] = usr_in[1].vld && usr_in_rdy[1] && !mute;
		push[2] = rx_push[0];
		push[3] = rx_push[1];
		pop[0] = tx_pop_pri;
		pop[1] = tx_pop_sec;
		pop[2] = rx_pop[0];
		pop[3] = rx_pop[1];
		din[0] = usr_in[0].data;
		din[1] = usr_in[1].data;
		din[2] = rx_ovh_byte;
		din[3] = rx_ovh_byte;
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			rx_pop[c] = (!usr_out[c].vld || usr_out_rdy[c]) && cnt_r[c+2] != '0;
		end
	end

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			usr_out <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (rx_pop[c]) begin
					usr_out[c].vld <= 1'b1;
					usr_out[c].data <= mem_r[c+2][rp_r[c+2]];
				end else if (usr_out_rdy[c]) begin
					usr_out[c].vld <= 1'b0;
				end
			end
		end
	end

	// station link pin: three stages, a change counts once stages two and three agree
	logic [2:0] slc_sync_r;
	logic slc_in_r;
	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			// start at the idle mark so no false start bit goes out after reset
			slc_sync_r <= 3'h7;
			slc_in_r <= 1'b1;
		end else begin
			slc_sync_r <= {slc_sync_r[1:0], slc_in_pin};
			if (slc_sync_r[1] == slc_sync_r[2]) begin
				slc_in_r <= slc_sync_r[2];
			end
		end
	end

	// transmit overhead; enhanced bytes are taken at the flag byte ahead of them
	logic [7:0] pri_hold_r;
	logic [7:0] sec_hold_r;
	logic pri_flag_r;
	logic sec_flag_r;
	assign tx_pop_pri = tx_ovh_req && enh_act_r && tx_ovh_idx == `IOM_BYTE_FLAG1 && cnt_r[0] != '0;
	assign tx_pop_sec = tx_ovh_req && enh_act_r && tx_ovh_idx == `IOM_BYTE_HK32 && cnt_r[1] != '0;

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			pri_hold_r <= 8'h00;
			sec_hold_r <= 8'h00;
			pri_flag_r <= 1'b0;
			sec_flag_r <= 1'b0;
		end else if (tx_ovh_req) begin
			if (tx_ovh_idx == `IOM_BYTE_FLAG1) begin
				pri_flag_r <= tx_pop_pri;
				pri_hold_r <= mem_r[0][rp_r[0]];
			end
			if (tx_ovh_idx == `IOM_BYTE_HK32) begin
				sec_flag_r <= tx_pop_sec;
				sec_hold_r <= mem_r[1][rp_r[1]];
			end
		end
	end

	logic [7:0] tx_nxt;
	always_comb begin
		tx_nxt = 8'h00;
		case (tx_ovh_idx)
			`IOM_BYTE_FLAG1: begin
				tx_nxt[`IOM_BIT1] = tx_pop_pri;
			end
			`IOM_BYTE_SIG16: begin
				// one byte per frame in 16 and one in 48: 16 bits per 512
				tx_nxt = (enh_act_r && pri_flag_r) ? pri_hold_r : 8'h00;
			end
			`IOM_BYTE_HK32: begin
				tx_nxt[`IOM_BIT1] = enh_act_r ? 1'b0 : slc_in_r;
				tx_nxt[`IOM_BIT2] = faw_tx_bit;
				tx_nxt[`IOM_BIT3] = ctrl_r[`IOM_CTRL_BWD_TX];
				tx_nxt[`IOM_BIT4] = mf_tx_bit;
				tx_nxt[`IOM_BIT6] = tx_pop_sec;
			end
			`IOM_BYTE_SIG48: begin
				tx_nxt = (enh_act_r && sec_flag_r) ? sec_hold_r : 8'h00;
			end
			default: begin
				tx_nxt = 8'h00;
			end
		endcase
	end

	// only the overhead slots are answered; the framer owns the 15/16 data share
	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			tx_ovh_vld <= 1'b0;
			tx_ovh_byte <= 8'h00;
		end else begin
			tx_ovh_vld <= tx_ovh_req;
			tx_ovh_byte <= tx_ovh_req ? tx_nxt : 8'h00;
		end
	end

	// receive overhead
	logic rx_pri_flag_r;
	logic rx_sec_flag_r;
	logic hk_rx;
	assign hk_rx = rx_ovh_vld && rx_ovh_idx == `IOM_BYTE_HK32;
	assign rx_push[0] = rx_ovh_vld && enh_act_r && rx_ovh_idx == `IOM_BYTE_SIG16 && rx_pri_flag_r;
	assign rx_push[1] = rx_ovh_vld && enh_act_r && rx_ovh_idx == `IOM_BYTE_SIG48 && rx_sec_flag_r;

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			rx_pri_flag_r <= 1'b0;
			rx_sec_flag_r <= 1'b0;
		end else if (rx_ovh_vld) begin
			if (rx_ovh_idx == `IOM_BYTE_FLAG1) begin
				rx_pri_flag_r <= rx_ovh_byte[`IOM_BIT1];
			end
			if (rx_ovh_idx == `IOM_BYTE_HK32) begin
				rx_sec_flag_r <= enh_act_r && rx_ovh_byte[`IOM_BIT6];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			slc_out_pin <= 1'b1;
			bwd_alarm_rx <= 1'b0;
			mf_rx_bit <= 1'b0;
			faw_err <= 1'b0;
		end else begin
			faw_err <= hk_rx && rx_ovh_byte[`IOM_BIT2] != faw_exp_bit;
			if (hk_rx) begin
				bwd_alarm_rx <= rx_ovh_byte[`IOM_BIT3];
				mf_rx_bit <= rx_ovh_byte[`IOM_BIT4];
				if (!enh_act_r) begin
					// raw bit: the user oversamples it, no clock goes with it
					slc_out_pin <= rx_ovh_byte[`IOM_BIT1];
				end
			end
		end
	end

	// sticky status, write one to clear; a new event in the same cycle wins
	logic [4:0] sticky_r;
	logic [4:0] clr;
	assign clr = (reg_wr && reg_addr == `IOM_OFS_STAT) ? reg_wdata[4:0] : 5'h00;
	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			sticky_r <= 5'h00;
		end else begin
			sticky_r <= (sticky_r & ~clr) | {faw_err, purge};
		end
	end

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`IOM_OFS_CTRL: reg_rdata <= ctrl_r;
				`IOM_OFS_STAT: reg_rdata <= {25'h0, enh_act_r, bwd_alarm_rx, sticky_r};
				`IOM_OFS_FILL: reg_rdata <= {8'(cnt_r[3]), 8'(cnt_r[2]), 8'(cnt_r[1]), 8'(cnt_r[0])};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_s);

	sequence s_hk_req;
		tx_ovh_req && tx_ovh_idx == `IOM_BYTE_HK32;
	endsequence

	chk_raw_bit_tx: assert property ((s_hk_req and !enh_act_r) |=>
		tx_ovh_byte[`IOM_BIT1] == $past(slc_in_r)) else $error("station bit not sent");
	chk_spare_zero: assert property ((s_hk_req and !enh_act_r) |=>
		tx_ovh_byte[3:0] == 4'h0) else $error("spare bits not zero");
	chk_faw_bit_tx: assert property (s_hk_req |=>
		tx_ovh_byte[`IOM_BIT2] == $past(faw_tx_bit)) else $error("alignment bit wrong");
	chk_alarm_rx_in: assert property (hk_rx |=>
		bwd_alarm_rx == $past(rx_ovh_byte[`IOM_BIT3])) else $error("alarm not taken");
	chk_mf_bit_tx: assert property (s_hk_req |=>
		tx_ovh_byte[`IOM_BIT4] == $past(mf_tx_bit)) else $error("multiframe bit wrong");
	chk_sig_kept: assert property (tx_ovh_req && !enh_act_r &&
		tx_ovh_idx == `IOM_BYTE_SIG16 |=> tx_ovh_byte == 8'h00) else $error("signal byte used");
	chk_closed_net: assert property (enh_act_r |->
		$past(ctrl_r[`IOM_CTRL_CLOSED_NET])) else $error("enhanced without closed net");
	chk_purge_empty: assert property (purge[0] |=> cnt_r[0] == '0 ##0 sticky_r[0])
		else $error("overflow did not purge");
	chk_mute_input: assert property (mute |=> cnt_r[0] <= $past(cnt_r[0]) &&
		cnt_r[1] <= $past(cnt_r[1])) else $error("input taken while muted");
endmodule

// >>> sim/iom_far_end.sv
// far-end deframer model: replays one received overhead frame per call
`timescale 1ns/1ps
`include "iom_defs.svh"
module iom_far_end (
	input wire logic mclk,
	output logic rx_ovh_vld,
	output logic [5:0] rx_ovh_idx,
	output logic [7:0] rx_ovh_byte
);
	// byte order 1,16,32,48 and bit layout match the near end
	localparam logic [23:0] SLOTS = {`IOM_BYTE_FLAG1, `IOM_BYTE_SIG16,
		`IOM_BYTE_HK32, `IOM_BYTE_SIG48};
	initial begin
		rx_ovh_vld = 1'b0;
		rx_ovh_idx = 6'h00;
		rx_ovh_byte = 8'h00;
	end
	// gap sets how slowly the bytes follow each other
	task automatic send_frame(input logic [31:0] f, input int gap);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			rx_ovh_vld <= 1'b1;
			rx_ovh_idx <= SLOTS[23-6*i -: 6];
			rx_ovh_byte <= f[31-8*i -: 8];
			@(posedge mclk);
			rx_ovh_vld <= 1'b0;
			// released lane shows the inverse so stale data cannot pass
			rx_ovh_byte <= ~f[31-8*i -: 8];
			repeat (gap) @(posedge mclk);
		end
	endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the overhead multiplexer
`timescale 1ns/1ps
`include "iom_defs.svh"
module testbench import iom_pkg::*; ();
	logic mclk, rst_b, reg_wr, reg_rd, tx_ovh_req, faw_tx_bit, mf_tx_bit, tx_ovh_vld;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [5:0] tx_ovh_idx, rx_ovh_idx;
	logic [7:0] tx_ovh_byte, rx_ovh_byte;
	logic rx_ovh_vld, faw_exp_bit, faw_err, mf_rx_bit, bwd_alarm_rx, slc_in_pin, slc_out_pin;
	iom_byte_t [1:0] usr_in, usr_out;
	logic [1:0] usr_in_rdy, usr_out_rdy;
	int num_errors = 0;
	int total_checks = 0;
	localparam logic [23:0] SLOTS = {`IOM_BYTE_FLAG1, `IOM_BYTE_SIG16,
		`IOM_BYTE_HK32, `IOM_BYTE_SIG48};

	iom_overhead_mux iom_overhead_mux_i (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .tx_ovh_req, .tx_ovh_idx, .faw_tx_bit, .mf_tx_bit, .tx_ovh_vld,
		.tx_ovh_byte, .rx_ovh_vld, .rx_ovh_idx, .rx_ovh_byte, .faw_exp_bit, .faw_err,
		.mf_rx_bit, .bwd_alarm_rx, .slc_in_pin, .slc_out_pin, .usr_in, .usr_in_rdy,
		.usr_out, .usr_out_rdy);
	iom_far_end iom_far_end_i (.mclk, .rx_ovh_vld, .rx_ovh_idx, .rx_ovh_byte);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// m masks the fields that the check cares about
	task automatic rd(input logic [3:0] a, input logic [31:0] m, e, input string n);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata & m);
	endtask

	// one frame of requests; data bytes 16 and 48 are only checked when full is set
	task automatic txf(input logic [31:0] e, input logic full);
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			tx_ovh_req <= 1'b1;
			tx_ovh_idx <= SLOTS[23-6*i -: 6];
			@(posedge mclk);
			tx_ovh_req <= 1'b0;
			#1 chk("tx valid", 32'h1, tx_ovh_vld);
			if (full || i == 0 || i == 2) chk("tx byte", e[31-8*i -: 8], tx_ovh_byte);
		end
	endtask

	task automatic push(input int ch, input logic [7:0] d);
		int n;
		@(posedge mclk);
		usr_in[ch].vld <= 1'b1;
		usr_in[ch].data <= d;
		#1;
		for (n = 0; n < 50 && usr_in_rdy[ch] !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		if (n == 50) chk("push ready", 32'h1, 32'h0);
		@(posedge mclk);
		usr_in[ch].vld <= 1'b0;
	endtask

	task automatic rx_chk(input logic [2:0] e);
		repeat (3) @(posedge mclk);
		chk("rx levels", e, {slc_out_pin, bwd_alarm_rx, mf_rx_bit});
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		final_report();
	end

	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		tx_ovh_req = 1'b0;
		tx_ovh_idx = 6'h00;
		faw_tx_bit = 1'b0;
		mf_tx_bit = 1'b0;
		faw_exp_bit = 1'b0;
		slc_in_pin = 1'b1;
		usr_in = '0;
		usr_out_rdy = 2'b00;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("idle mark", 32'h1, slc_out_pin);
		wr(4'hC, '1);
		rd(`IOM_OFS_CTRL, '1, `IOM_CTRL_RST, "ctrl");
		rd(`IOM_OFS_STAT, '1, 32'h0, "stat");
		rd(`IOM_OFS_FILL, '1, 32'h0, "fill");
		rd(4'hC, '1, 32'h0, "unmapped");
		$display("test reset done");
		faw_tx_bit <= 1'b1;
		wr(`IOM_OFS_CTRL, 32'h8);
		txf(32'h0000_E000, 1'b0);
		slc_in_pin <= 1'b0;
		faw_tx_bit <= 1'b0;
		mf_tx_bit <= 1'b1;
		wr(`IOM_OFS_CTRL, 32'h0);
		repeat (4) @(posedge mclk);
		txf(32'h0000_1000, 1'b0);
		iom_far_end_i.send_frame(32'h0000_7F00, 0);
		rx_chk(3'b011);
		rd(`IOM_OFS_STAT, '1, 32'h30, "stat faw");
		wr(`IOM_OFS_STAT, 32'h10);
		rd(`IOM_OFS_STAT, '1, 32'h20, "stat clr");
		iom_far_end_i.send_frame(32'h0000_8000, 3);
		rx_chk(3'b100);
		$display("test normal done");
		for (int m = 0; m < 4; m++) begin
			wr(`IOM_OFS_CTRL, 32'h5 | (m << 4));
			rd(`IOM_OFS_STAT, 32'h40, (m < 3) ? 32'h40 : 32'h0, "enh");
		end
		wr(`IOM_OFS_CTRL, 32'h1);
		rd(`IOM_OFS_STAT, 32'h40, 32'h0, "enh open net");
		wr(`IOM_OFS_CTRL, 32'h5);
		rd(`IOM_OFS_CTRL, '1, 32'h5, "ctrl back");
		slc_in_pin <= 1'b1;
		faw_tx_bit <= 1'b1;
		push(0, 8'hA5);
		push(1, 8'h3C);
		repeat (4) @(posedge mclk);
		txf(32'h80A5_543C, 1'b1);
		txf(32'h0000_5000, 1'b1);
		iom_far_end_i.send_frame(32'h805A_04C3, 3);
		rx_chk(3'b100);
		chk("out pri", 32'h15A, usr_out[0]);
		chk("out sec", 32'h1C3, usr_out[1]);
		$display("test enhanced done");
		wr(`IOM_OFS_CTRL, 32'h7);
		// two-wire with output pending: the offered byte must never be taken
		usr_in[0].data <= 8'h11;
		usr_in[0].vld <= 1'b1;
		repeat (4) @(posedge mclk);
		usr_in[0].vld <= 1'b0;
		#1 chk("rdy muted", 32'h0, usr_in_rdy);
		rd(`IOM_OFS_FILL, 32'hFF, 32'h0, "fill muted");
		@(posedge mclk);
		usr_out_rdy <= 2'b11;
		repeat (3) @(posedge mclk);
		#1 chk("drained", 32'h0, {usr_out[1].vld, usr_out[0].vld});
		wr(`IOM_OFS_CTRL, 32'h5);
		for (int i = 0; i < 32; i++) push(0, i[7:0]);
		rd(`IOM_OFS_FILL, 32'hFF, 32'h20, "fill full");
		push(0, 8'hEE);
		rd(`IOM_OFS_FILL, 32'hFF, 32'h0, "fill purged");
		rd(`IOM_OFS_STAT, '1, 32'h41, "stat ovf");
		wr(`IOM_OFS_STAT, 32'h1);
		rd(`IOM_OFS_STAT, '1, 32'h40, "stat ovf clr");
		$display("test fifo done");
		final_report();
	end
endmodule
